/* sfc_cmd_port.sv */
// Serial command front end of the flash: byte assembly, opcode decode,
// address collection, read and status streaming, write enable and busy.
// Assumes link pins are asynchronous and an external engine runs erase and
// program timing, answering each started operation with op_done_i.
`timescale 1ns/1ns
module sfc_cmd_port
  import sfc_pkg::*;
(
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       sck_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       si_i,
  input  wire logic                       wp_n_i,
  input  wire logic                       hold_n_i,
  input  wire logic                       op_done_i,
  output logic                            so_o,
  output logic                            so_oe_o,
  output logic                            op_start_o,
  output sfc_pkg::sfc_op_kind_t           op_kind_o,
  output logic      [sfc_pkg::ADDR_W-1:0] op_addr_o,
  output logic                            busy_o,
  output logic                            wen_o,
  output logic                            power_down_o,
  output logic                            spi_mode3_o,
  output logic      [sfc_pkg::BYTE_W-1:0] status_o
);
  import sfc_pkg::*;

  logic              cs_n_s;
  logic              sck_s;
  logic              si_s;
  logic              wp_n_s;
  logic              hold_n_s;
  logic              cs_prev_r;
  logic              sck_prev_r;
  sfc_state_t        state_r;
  logic [2:0]        bit_cnt_r;
  logic [2:0]        out_cnt_r;
  logic [6:0]        in_sr_r;
  logic [7:0]        opcode_r;
  logic [23:0]       addr_r;
  logic [1:0]        addr_cnt_r;
  logic [7:0]        wrsr_data_r;
  logic              prog_seen_r;
  logic [7:0]        prog_low_r;
  logic [ADDR_W-1:0] rd_addr_r;
  logic [7:0]        out_sr_r;
  logic              out_en_r;
  logic              pd_r;
  logic              wen_r;
  logic              busy_r;
  logic [7:0]        status_nv_r;
  logic              mem_we_r;
  logic [ADDR_W-1:0] mem_waddr_r;
  logic [7:0]        mem_wdata_r;
  logic [7:0]        mem_rdata;
  logic              active;
  logic              run;
  logic              cs_fall;
  logic              cs_rise;
  logic              sck_rise;
  logic              sck_fall;
  logic              byte_done;
  logic [7:0]        byte_in;
  logic [23:0]       addr_full;
  logic              write_ok;
  logic              wrsr_locked;
  logic              launch;
  logic [7:0]        status_byte;
  sfc_op_kind_t      launch_kind;

  // Maps an opcode to the internal write operation it starts
  function automatic sfc_op_kind_t op_kind_of(input logic [7:0] op);
    sfc_op_kind_t k;
    k = OPK_NONE;
    case (op)
      OP_SMALL_ERA, OP_SMALL_ERB: k = OPK_SMALL_ERASE;
      OP_SECT_ERA:                k = OPK_SECTOR_ERASE;
      OP_CHIP_ERA, OP_CHIP_ERB:   k = OPK_CHIP_ERASE;
      OP_PROGRAM:                 k = OPK_PROGRAM;
      OP_STAT_WRITE:              k = OPK_STATUS_WRITE;
      default:                    k = OPK_NONE;
    endcase
    return k;
  endfunction

  sfc_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .d_i       ({cs_n_i, sck_i, si_i, wp_n_i, hold_n_i}),
    .q_o       ({cs_n_s, sck_s, si_s, wp_n_s, hold_n_s})
  );

  sfc_mem u_mem (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .we_i      (mem_we_r),
    .waddr_i   (mem_waddr_r),
    .wdata_i   (mem_wdata_r),
    .raddr_i   (rd_addr_r),
    .rdata_o   (mem_rdata)
  );

  assign active      = ~cs_n_s;
  assign run         = active & hold_n_s;
  assign cs_fall     = ~cs_n_s & cs_prev_r;
  assign cs_rise     = cs_n_s & ~cs_prev_r;
  assign sck_rise    = run & sck_s & ~sck_prev_r;
  assign sck_fall    = run & ~sck_s & sck_prev_r;
  assign byte_done   = sck_rise & (bit_cnt_r == BIT_LAST);
  assign byte_in     = {in_sr_r, si_s};
  assign addr_full   = {addr_r[15:0], byte_in};
  assign write_ok    = wen_r & ~busy_r;
  assign wrsr_locked = status_nv_r[ST_LOCK_BIT] & ~wp_n_s;
  assign launch_kind = op_kind_of(opcode_r);
  assign status_byte = (status_nv_r & ST_NV_MASK) | {6'h00, wen_r, busy_r};
  // Launch only at deselect; a cut or overlong frame starts no write, except a program frame cut inside any data byte after the first
  assign launch      = cs_rise & write_ok & ~pd_r
                     & ((state_r == ST_ARMED) | ((state_r == ST_PROG) & prog_seen_r))
                     & ~((launch_kind == OPK_STATUS_WRITE) & wrsr_locked);

  // Edge history of the synchronised pins
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_prev_r  <= 1'b1;
      sck_prev_r <= 1'b0;
    end else begin
      cs_prev_r  <= cs_n_s;
      sck_prev_r <= sck_s;
    end
  end

  // Clock level at selection decides the mode
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_mode3_o <= 1'b0;
    end else if (cs_fall) begin
      spi_mode3_o <= sck_s;
    end
  end

  // Input shifter, most significant bit first
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_r <= '0;
      in_sr_r   <= '0;
    end else if (!active || cs_fall) begin
      bit_cnt_r <= '0;
      in_sr_r   <= '0;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      in_sr_r   <= byte_in[6:0];
    end
  end

  // Transaction sequencer
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r     <= ST_IDLE;
      opcode_r    <= '0;
      addr_r      <= '0;
      addr_cnt_r  <= '0;
      wrsr_data_r <= '0;
      prog_seen_r <= 1'b0;
      prog_low_r  <= '0;
      rd_addr_r   <= '0;
    end else if (!active) begin
      state_r     <= ST_IDLE;
      prog_seen_r <= 1'b0;
    end else if (cs_fall) begin
      state_r     <= ST_CMD;
      addr_cnt_r  <= '0;
      prog_seen_r <= 1'b0;
    end else if (byte_done) begin
      case (state_r)
        ST_CMD: begin
          opcode_r <= byte_in;
          if (pd_r) begin
            state_r <= ST_IGNORE;
          end else begin
            case (byte_in)
              OP_READ, OP_FAST_READ, OP_SMALL_ERA, OP_SMALL_ERB, OP_SECT_ERA, OP_PROGRAM: begin
                state_r <= ST_ADDR;
              end
              OP_CHIP_ERA, OP_CHIP_ERB: begin
                state_r <= ST_ARMED;
              end
              OP_STAT_READ: begin
                state_r <= ST_STAT;
              end
              OP_STAT_WRITE: begin
                state_r <= ST_WRSR;
              end
              default: begin
                state_r <= ST_IGNORE;
              end
            endcase
          end
        end
        ST_ADDR: begin
          addr_r     <= addr_full;
          addr_cnt_r <= addr_cnt_r + 2'h1;
          if (addr_cnt_r == ADDR_BYTE_LAST) begin
            rd_addr_r  <= addr_full[ADDR_W-1:0];
            prog_low_r <= byte_in;
            case (opcode_r)
              OP_READ:      state_r <= ST_READ;
              OP_FAST_READ: state_r <= ST_DUMMY;
              OP_PROGRAM:   state_r <= ST_PROG;
              default:      state_r <= ST_ARMED;
            endcase
          end
        end
        ST_DUMMY: begin
          state_r <= ST_READ;
        end
        ST_READ: begin
          rd_addr_r <= rd_addr_r + 19'h00001;
        end
        ST_PROG: begin
          prog_seen_r <= 1'b1;
          prog_low_r  <= prog_low_r + 8'h01;
        end
        ST_WRSR: begin
          wrsr_data_r <= byte_in;
          state_r     <= ST_ARMED;
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end else if (sck_rise && state_r == ST_ARMED) begin
      state_r <= ST_IGNORE;
    end
  end

  // Program data go straight into the array while writes are allowed
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_we_r    <= 1'b0;
      mem_waddr_r <= '0;
      mem_wdata_r <= '0;
    end else begin
      mem_we_r    <= byte_done & (state_r == ST_PROG) & write_ok;
      mem_waddr_r <= {addr_r[ADDR_W-1:8], prog_low_r};
      mem_wdata_r <= byte_in;
    end
  end

  // Output shifter for read data and repeating status
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_cnt_r <= '0;
      out_sr_r  <= '0;
      out_en_r  <= 1'b0;
      so_o      <= 1'b0;
    end else if (!active || cs_fall) begin
      out_cnt_r <= '0;
      out_en_r  <= 1'b0;
    end else if (sck_fall && (state_r == ST_READ || state_r == ST_STAT)) begin
      out_en_r  <= 1'b1;
      out_cnt_r <= out_cnt_r + 3'h1;
      if (out_cnt_r == 3'h0) begin
        so_o     <= (state_r == ST_READ) ? mem_rdata[7] : status_byte[7];
        out_sr_r <= (state_r == ST_READ) ? {mem_rdata[6:0], 1'b0} : {status_byte[6:0], 1'b0};
      end else begin
        so_o     <= out_sr_r[7];
        out_sr_r <= {out_sr_r[6:0], 1'b0};
      end
    end
  end

  // Output released when deselected, paused or powered down
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      so_oe_o <= 1'b0;
    end else begin
      so_oe_o <= run & out_en_r & ~pd_r;
    end
  end

  // Power-down state
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pd_r <= 1'b0;
    end else if (byte_done && state_r == ST_CMD) begin
      if (pd_r && byte_in == OP_EXIT_PD) begin
        pd_r <= 1'b0;
      end else if (!pd_r && byte_in == OP_POWER_DOWN) begin
        pd_r <= 1'b1;
      end
    end
  end

  // Write enable latch; a set command wins over completion clearing
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wen_r <= 1'b0;
    end else if (byte_done && state_r == ST_CMD && !pd_r && byte_in == OP_WR_ENABLE) begin
      wen_r <= 1'b1;
    end else if (byte_done && state_r == ST_CMD && !pd_r && byte_in == OP_WR_DISABLE) begin
      wen_r <= 1'b0;
    end else if (op_done_i && busy_r) begin
      wen_r <= 1'b0;
    end
  end

  // Busy flag and operation launch toward the erase/program engine
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r     <= 1'b0;
      op_start_o <= 1'b0;
      op_kind_o  <= OPK_NONE;
      op_addr_o  <= '0;
    end else begin
      op_start_o <= launch;
      if (launch) begin
        busy_r    <= 1'b1;
        op_kind_o <= launch_kind;
        op_addr_o <= addr_r[ADDR_W-1:0];
      end else if (op_done_i) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Non-volatile status bits; only writable bits are taken
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_nv_r <= ST_NV_RESET;
    end else if (launch && launch_kind == OPK_STATUS_WRITE) begin
      status_nv_r <= wrsr_data_r & ST_NV_MASK;
    end
  end

  assign busy_o       = busy_r;
  assign wen_o        = wen_r;
  assign power_down_o = pd_r;
  assign status_o     = status_byte;
endmodule

/* sfc_cmd_port_props.sv */
// Port-level checks for the serial flash command port.
// Assumes one system clock domain with an asynchronous active-low reset.
`timescale 1ns/1ns
module sfc_cmd_port_props
  import sfc_pkg::*;
(
  input wire logic                       clk_sys_i,
  input wire logic                       rst_n_i,
  input wire logic                       sck_i,
  input wire logic                       cs_n_i,
  input wire logic                       si_i,
  input wire logic                       wp_n_i,
  input wire logic                       hold_n_i,
  input wire logic                       op_done_i,
  input wire logic                       so_o,
  input wire logic                       so_oe_o,
  input wire logic                       op_start_o,
  input wire sfc_pkg::sfc_op_kind_t      op_kind_o,
  input wire logic [sfc_pkg::ADDR_W-1:0] op_addr_o,
  input wire logic                       busy_o,
  input wire logic                       wen_o,
  input wire logic                       power_down_o,
  input wire logic                       spi_mode3_o,
  input wire logic [sfc_pkg::BYTE_W-1:0] status_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  start_busy_a:
    assert property (op_start_o |-> busy_o) else $error("busy not raised at launch");
  launch_wen_a:
    assert property (op_start_o |-> $past(wen_o)) else $error("launch without write enable");
  done_clear_a:
    assert property (op_done_i && busy_o && !op_start_o |=> !busy_o && !wen_o) else $error("done left flags");
  launch_after_cs_a:
    assert property (op_start_o |-> $past(cs_n_i, 2)) else $error("launch while selected");
  standby_quiet_a:
    assert property (cs_n_i [*5] |-> !so_oe_o) else $error("output driven while deselected");
  hold_quiet_a:
    assert property (!hold_n_i [*5] |-> !so_oe_o) else $error("output driven while paused");
  pd_quiet_a:
    assert property (power_down_o |-> !so_oe_o && !op_start_o) else $error("activity in power down");
  so_on_fall_a:
    assert property (so_oe_o && $changed(so_o) |-> !$past(sck_i, 2)) else $error("output moved off falling edge");
  kind_hold_a:
    assert property (!op_start_o |-> $stable(op_kind_o) && $stable(op_addr_o)) else $error("op fields moved");
  lock_guard_a:
    assert property (op_start_o && op_kind_o == OPK_STATUS_WRITE |-> wp_n_i || !$past(status_o[ST_LOCK_BIT]))
      else $error("locked status rewritten");
  cover property (op_start_o && op_kind_o == OPK_CHIP_ERASE);
  cover property (so_oe_o && spi_mode3_o);
  cover property (power_down_o);
endmodule

bind sfc_cmd_port sfc_cmd_port_props sfc_cmd_port_props_inst (.*);

/* sfc_mem.sv */
// Byte-wide array backing store with one write port and a registered read port.
// Assumes a single clock; read data follow the address by one edge.
`timescale 1ns/1ns
module sfc_mem
  import sfc_pkg::*;
(
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       we_i,
  input  wire logic [sfc_pkg::ADDR_W-1:0] waddr_i,
  input  wire logic [sfc_pkg::BYTE_W-1:0] wdata_i,
  input  wire logic [sfc_pkg::ADDR_W-1:0] raddr_i,
  output logic      [sfc_pkg::BYTE_W-1:0] rdata_o
);
  logic [BYTE_W-1:0] mem_r [MEM_DEPTH];

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule

/* sfc_pkg.sv */
// Constants, opcodes and types shared by the serial flash command port.
// Assumes a 10 MHz system clock that oversamples the serial link pins.
// Functional notes
// - Command, address and write data bits are captured on serial clock rising edges.
// - Serial output bits change on serial clock falling edges.
// - Active only while chip select is low; standby and bus ignored when high.
// - With write protect low, a set status lock bit blocks status writes.
// - Pause pin low freezes the transaction; releasing it high resumes.
// - Chip select falling edge starts a new transaction with a command byte.
// - Input is grouped into 8-bit bytes; the first byte names the operation.
// - Clock level at chip select fall picks mode 0 (low) or mode 3 (high).
// - Opcode 03h, three address bytes, then read data streams out.
// - Opcode 0Bh, three address bytes, one dummy byte, then read data.
// - Opcode 20h or D7h plus address erases the containing 4K small sector.
// - Opcode D8h plus address erases the containing 64K sector.
// - Lone opcode 60h or C7h erases the whole array.
// - Opcode 02h, address, then program data bytes until chip select rises.
// - Opcode 05h returns the status byte with no address phase.
// - Opcode 01h followed by exactly one byte writes the status value.
// - Opcode ABh while powered down leaves the low-power state.
// - Address bits 23 to 19 are ignored; only 19 bits are decoded.
// - Don't-care byte contents never affect the operation.
// - Array is eight 64K sectors of sixteen 4K small sectors, top 07FFFFh.
// - Read address increments per byte and wraps from top to zero.
// - 06h sets, 04h clears write enable; writes refused while it is clear.
// - Busy status bit is 1 while an erase, program or status write runs.
package sfc_pkg;
  localparam int          BYTE_W        = 8;
  localparam int          ADDR_W        = 19;
  localparam int          MEM_DEPTH     = 524288;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [1:0]  ADDR_BYTE_LAST = 2'h2;
  localparam logic [7:0]  OP_READ       = 8'h03;
  localparam logic [7:0]  OP_FAST_READ  = 8'h0B;
  localparam logic [7:0]  OP_SMALL_ERA  = 8'h20;
  localparam logic [7:0]  OP_SMALL_ERB  = 8'hD7;
  localparam logic [7:0]  OP_SECT_ERA   = 8'hD8;
  localparam logic [7:0]  OP_CHIP_ERA   = 8'h60;
  localparam logic [7:0]  OP_CHIP_ERB   = 8'hC7;
  localparam logic [7:0]  OP_PROGRAM    = 8'h02;
  localparam logic [7:0]  OP_WR_ENABLE  = 8'h06;
  localparam logic [7:0]  OP_WR_DISABLE = 8'h04;
  localparam logic [7:0]  OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0]  OP_STAT_READ  = 8'h05;
  localparam logic [7:0]  OP_STAT_WRITE = 8'h01;
  localparam logic [7:0]  OP_EXIT_PD    = 8'hAB;
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_WEN_BIT    = 1;
  localparam int          ST_LOCK_BIT   = 7;
  localparam logic [7:0]  ST_NV_MASK    = 8'hBC;
  localparam logic [7:0]  ST_NV_RESET   = 8'h00;
  localparam logic [7:0]  ST_VOL_MASK   = 8'h03;

  typedef enum logic [2:0] {
    OPK_NONE, OPK_SMALL_ERASE, OPK_SECTOR_ERASE, OPK_CHIP_ERASE, OPK_PROGRAM, OPK_STATUS_WRITE
  } sfc_op_kind_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_READ, ST_STAT, ST_PROG, ST_WRSR, ST_ARMED, ST_IGNORE
  } sfc_state_t;
endpackage

/* sfc_spi_host.sv */
// SPI host model that frames bytes towards the flash command port.
// Assumes the 100 ns bench clock; serial clock half period is 4 clock cycles.
`timescale 1ns/1ns
module sfc_spi_host (
  input  wire logic clk_sys_i,
  input  wire logic so_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // Idle clock level picks the mode; clock stands still outside frames
  task automatic start(input logic mode3);
    sck_o <= mode3;
    repeat (4) @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      sck_o <= 1'b0;
      si_o <= tx[i];
      repeat (4) @(posedge clk_sys_i);
      sck_o <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rx[i] = so_i;
      repeat (2) @(posedge clk_sys_i);
    end
  endtask
  task automatic stop(input logic mode3);
    sck_o <= mode3;
    repeat (4) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule

/* sfc_sync.sv */
// Two-stage synchroniser for pins arriving from outside the system clock.
// Assumes each bit is an independent level.
`timescale 1ns/1ns
module sfc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  // Resets to the deselected, unpaused pin levels
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '1;
      q_o    <= '1;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

/* test_serial_flash_command_port.sv */
// Self-checking bench for the serial flash command port.
// Assumes the SPI host model drives the link; the bench plays the engine.
`timescale 1ns/1ns
module test_serial_flash_command_port;
  import sfc_pkg::*;
  logic              clk_sys_i, rst_n_i, sck_i, cs_n_i, si_i, wp_n_i, hold_n_i, op_done_i;
  logic              so_o, so_oe_o, op_start_o, busy_o, wen_o, power_down_o, spi_mode3_o, so_w;
  sfc_op_kind_t      op_kind_o;
  logic [ADDR_W-1:0] op_addr_o;
  logic [BYTE_W-1:0] status_o, r;
  logic [7:0]        rdq[$], q[$];
  logic [7:0]        ops[5] = '{OP_SMALL_ERA, OP_SMALL_ERB, OP_SECT_ERA, OP_CHIP_ERA, OP_CHIP_ERB};
  sfc_op_kind_t      kinds[5] = '{OPK_SMALL_ERASE, OPK_SMALL_ERASE, OPK_SECTOR_ERASE, OPK_CHIP_ERASE, OPK_CHIP_ERASE};
  int                n_fail = 0, check_count = 0, cycles = 0, n_start = 0, s;

  // Released output shows a toggling pattern, never the last value
  assign so_w = so_oe_o ? so_o : cycles[0];
  sfc_cmd_port sfc_cmd_port_inst (.*);
  sfc_spi_host sfc_spi_host_inst (.clk_sys_i(clk_sys_i), .so_i(so_w), .sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (op_start_o === 1'b1) n_start <= n_start + 1;
    if (cycles == 40000) begin
      n_fail++;
      results();
    end
  end

  task automatic results;
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic frame(input logic [7:0] b[$], input logic mode3);
    logic [7:0] x;
    rdq = {};
    sfc_spi_host_inst.start(mode3);
    foreach (b[i]) begin
      sfc_spi_host_inst.xfer(b[i], 8, x);
      rdq.push_back(x);
    end
    sfc_spi_host_inst.stop(mode3);
  endtask
  task automatic wr(input logic [7:0] b[$], input sfc_op_kind_t k, input logic [18:0] a);
    int s0;
    frame('{OP_WR_ENABLE}, 1'b0);
    chk("wen", 1, wen_o);
    s0 = n_start;
    frame(b, 1'b0);
    chk("launch", s0 + 1, n_start);
    chk("kind", k, op_kind_o);
    if (b.size() > 2) chk("addr", a, op_addr_o);
    chk("busy", 1, busy_o);
    op_done_i <= 1'b1;
    @(posedge clk_sys_i);
    op_done_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk("flags", 0, {busy_o, wen_o});
  endtask

  initial begin
    rst_n_i = 1'b0;
    wp_n_i = 1'b1;
    hold_n_i = 1'b1;
    op_done_i = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk("reset", 0, {status_o, busy_o, wen_o, power_down_o, op_start_o});
    s = n_start;
    frame('{OP_CHIP_ERA}, 1'b0);
    chk("refused", s, n_start);
    foreach (ops[i]) begin
      q = '{ops[i]};
      if (i < 3) q = '{ops[i], 8'hFF, 8'hF1, 8'h23};
      wr(q, kinds[i], 19'h7F123);
    end
    wr('{OP_PROGRAM, 8'hFF, 8'hFF, 8'hFF, 8'hA5}, OPK_PROGRAM, 19'h7FFFF);
    wr('{OP_PROGRAM, 8'h00, 8'h00, 8'h00, 8'h5A}, OPK_PROGRAM, 19'h00000);
    frame('{OP_READ, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00}, 1'b0);
    chk("read top", 8'hA5, rdq[4]);
    chk("read wrap", 8'h5A, rdq[5]);
    frame('{OP_FAST_READ, 8'h07, 8'hFF, 8'hFF, 8'h3C, 8'h00, 8'h00}, 1'b1);
    chk("fast top", 8'hA5, rdq[5]);
    chk("fast wrap", 8'h5A, rdq[6]);
    chk("mode3", 1, spi_mode3_o);
    frame('{OP_WR_ENABLE}, 1'b1);
    chk("wen m3", 1, wen_o);
    frame('{OP_WR_DISABLE}, 1'b0);
    chk("wdis", 0, {spi_mode3_o, wen_o});
    sfc_spi_host_inst.start(1'b0);
    sfc_spi_host_inst.xfer(8'hFF, 5, r);
    sfc_spi_host_inst.stop(1'b0);
    frame('{OP_WR_ENABLE}, 1'b0);
    chk("partial", 1, wen_o);
    wr('{OP_STAT_WRITE, 8'h80}, OPK_STATUS_WRITE, 19'h0);
    frame('{OP_STAT_READ, 8'h00, 8'h00}, 1'b0);
    chk("stat", 16'h8080, {rdq[1], rdq[2]});
    wp_n_i <= 1'b0;
    frame('{OP_WR_ENABLE}, 1'b0);
    s = n_start;
    frame('{OP_STAT_WRITE, 8'h00}, 1'b0);
    chk("locked", s, n_start);
    sfc_spi_host_inst.start(1'b0);
    sfc_spi_host_inst.xfer(OP_STAT_READ, 8, r);
    sfc_spi_host_inst.xfer(8'h00, 8, r);
    chk("stat lock", 8'h82, r);
    hold_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk("hold oe", 0, so_oe_o);
    sfc_spi_host_inst.xfer(8'h00, 3, r);
    hold_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    sfc_spi_host_inst.xfer(8'h00, 8, r);
    chk("hold resume", 8'h82, r);
    sfc_spi_host_inst.stop(1'b0);
    wp_n_i <= 1'b1;
    wr('{OP_STAT_WRITE, 8'h00}, OPK_STATUS_WRITE, 19'h0);
    chk("unlocked", 8'h00, status_o);
    frame('{OP_POWER_DOWN}, 1'b0);
    chk("pd", 1, power_down_o);
    frame('{OP_WR_ENABLE}, 1'b0);
    chk("pd ignore", 0, wen_o);
    frame('{OP_EXIT_PD}, 1'b0);
    chk("pd exit", 0, power_down_o);
    results();
  end
endmodule
